// [hw/shadow_pkg.sv]
// Package with register map, field layout and constants of the shadow configuration block.
// How it works
// - Every unit configuration register is 32 bits, readable and writable over the bus.
// - Software writes land in the shadow copy; active copy changes only on load.
// - A software token waits and is released at the next frame start.
// - The released token loads each unit's shadows as it passes, up to an end point.
// - A token reaching an end point raises a shadow load interrupt.
// - One trigger bit arms all fetch and external source units together.
// - Mixer secondary end point, when enabled, ends secondary tokens with an interrupt.
// - A setting picks primary or secondary token for loading the mixer shadows.
// - Generator input end points enabled means software starts downstream tokens itself.
// - A setting picks primary, secondary or own token for the generator shadows.
// - Signature unit follows pipeline tokens or issues its own token.
// - Signature unit is no end point; interrupts only after a real load.
// - Protected registers start locked; a key write toggles the lock.
// - Each event has enable, status, preset and clear bits.
// - Trigger and status go out to the system; status is pollable.
// - Capture and memory stream throttling are separate and divide by a fixed ratio.
// - Memory or capture display mode changes only between two frames.
// - Each stream and the constant colour layer can be switched off individually.
// - Split mode half width is limited to 1280 pixels.
package shadow_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_EV = 4;
  localparam logic [ADDR_W-1:0] LOCK_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] TRIG_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_ST_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_SET_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] FETCH_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] EXTERNAL_SOURCE_UNIT_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] MIXER_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] OTG_OFS = 8'h2C;
  localparam logic [ADDR_W-1:0] SIG_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] ACTIVE_DELTA = 8'h20;
  // Unlock key; the value is arbitrary.
  localparam logic [DATA_W-1:0] LOCK_KEY = 32'h0000A5C3;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h00000000;
  // Control register fields.
  localparam int CTL_THR_CAP = 0;
  localparam int CTL_THR_MEM = 1;
  localparam int CTL_MIX_EP = 2;
  localparam int CTL_OTG_EP = 3;
  localparam int CTL_MIX_SEL = 4;
  localparam int CTL_OTG_SEL = 5;
  localparam int CTL_SIG_OWN = 7;
  localparam logic [1:0] OTG_SEL_PRI = 2'h0;
  localparam logic [1:0] OTG_SEL_SEC = 2'h1;
  localparam logic [1:0] OTG_SEL_OWN = 2'h2;
  // Trigger register fields.
  localparam int TRG_SRC = 0;
  localparam int TRG_OTG = 1;
  localparam int TRG_SIG = 2;
  // Mixer and generator configuration fields.
  localparam int MIX_MEM_EN = 0;
  localparam int MIX_CAP_EN = 1;
  localparam int MIX_CONST_EN = 2;
  localparam int OTG_MODE = 0;
  localparam int OTG_WIDTH_LO = 16;
  localparam int WIDTH_W = 11;
  localparam logic [WIDTH_W-1:0] MAX_SPLIT_W = 11'h500;
  // Status register fields.
  localparam int ST_LOCKED = 3;
  localparam int ST_MODE = 4;
  // Event numbers.
  localparam int EV_MIX_END = 0;
  localparam int EV_OTG_END = 1;
  localparam int EV_DISP_END = 2;
  localparam int EV_SIG_LOAD = 3;
  // Throttle divides the stream clock enable by four.
  localparam int THR_W = 2;
  localparam logic [THR_W-1:0] THR_LAST = 2'h3;
  typedef enum logic {LOCKED, UNLOCKED} lock_e;
endpackage

// [hw/irq_if.sv]
// Interface joining the control logic to the event interrupt bank.
`timescale 1ns/1ps
`default_nettype none
interface irq_if;
  import shadow_pkg::*;
  logic [NUM_EV-1:0] event_hit;
  logic [NUM_EV-1:0] preset;
  logic [NUM_EV-1:0] clear;
  logic enable_wr;
  logic [NUM_EV-1:0] enable_wdata;
  logic [NUM_EV-1:0] enable;
  logic [NUM_EV-1:0] status;
  modport ctl (output event_hit, preset, clear, enable_wr, enable_wdata, input enable, status);
  modport bank (input event_hit, preset, clear, enable_wr, enable_wdata, output enable, status);
endinterface
`default_nettype wire

// [hw/shadow_reg.sv]
// One shadowed configuration word with its active copy.
`timescale 1ns/1ps
`default_nettype none
module shadow_reg
  import shadow_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic load,
  output logic [DATA_W-1:0] shadow_q,
  output logic [DATA_W-1:0] active_q
);
  logic [DATA_W-1:0] shadow_ff;
  logic [DATA_W-1:0] active_ff;

  // Software only ever reaches the shadow copy.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shadow_ff <= REG_RESET;
    else if (wr_en)
      shadow_ff <= wdata;
  end

  // Only a load moves the active copy, taking the shadow as it was before a same-cycle write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_ff <= REG_RESET;
    else if (load)
      active_ff <= shadow_ff;
  end

  assign shadow_q = shadow_ff;
  assign active_q = active_ff;

  shadow_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(load) |-> active_ff == $past(active_ff))
    else $error("active copy changed without a load");
endmodule // shadow_reg
`default_nettype wire

// [hw/irq_bank.sv]
// Event interrupt bank with enable, sticky status, preset and clear per event.
`timescale 1ns/1ps
`default_nettype none
module irq_bank
  import shadow_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  irq_if.bank bus
);
  logic [NUM_EV-1:0] enable_ff;
  logic [NUM_EV-1:0] status_ff;

  // Enable mask register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_ff <= '0;
    else if (bus.enable_wr)
      enable_ff <= bus.enable_wdata;
  end

  // Sticky status; an event or preset in the clear cycle wins so nothing is lost.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_ff <= '0;
    else
      status_ff <= (status_ff & ~bus.clear) | bus.event_hit | bus.preset;
  end

  assign bus.enable = enable_ff;
  assign bus.status = status_ff;

  status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_ff[0] && !bus.clear[0] |=> status_ff[0])
    else $error("status bit dropped without a clear");
  event_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus.event_hit[EV_DISP_END] |=> status_ff[EV_DISP_END])
    else $error("event did not set its status bit");
endmodule // irq_bank
`default_nettype wire

// [hw/shadow_cfg_ctrl.sv]
// Top of the shadow configuration block: APB registers, token pipeline, lock and throttle.
`timescale 1ns/1ps
`default_nettype none
module shadow_cfg_ctrl
  import shadow_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_start,
  output logic [DATA_W-1:0] fetch_cfg,
  output logic [DATA_W-1:0] external_source_unit_cfg,
  output logic [DATA_W-1:0] mixer_cfg,
  output logic [DATA_W-1:0] otg_cfg,
  output logic [DATA_W-1:0] sig_cfg,
  output logic capture_mode,
  output logic mem_layer_en,
  output logic cap_layer_en,
  output logic const_layer_en,
  output logic [WIDTH_W-1:0] split_width,
  output logic cap_clk_en,
  output logic mem_clk_en,
  output logic [NUM_EV-1:0] irq_trigger,
  output logic [NUM_EV-1:0] irq_status,
  output logic irq_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [DATA_W-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic nxt_err;
  logic wr;
  logic trig_wr;
  lock_e lock_ff;
  logic [DATA_W-1:0] ctrl_ff;
  logic pend_src_ff;
  logic pend_otg_ff;
  logic pend_sig_ff;
  logic mix_pri_ff;
  logic mix_sec_ff;
  logic otg_pri_ff;
  logic otg_sec_ff;
  logic down_ff;
  logic [NUM_EV-1:0] ev;
  logic src_go;
  logic otg_own_go;
  logic sig_go;
  logic load_mix;
  logic load_otg;
  logic load_sig;
  logic [DATA_W-1:0] sh_fetch;
  logic [DATA_W-1:0] sh_ext;
  logic [DATA_W-1:0] sh_mix;
  logic [DATA_W-1:0] sh_otg;
  logic [DATA_W-1:0] sh_sig;
  logic capture_mode_ff;
  logic mem_en_ff;
  logic cap_en_ff;
  logic const_en_ff;
  logic [WIDTH_W-1:0] split_ff;
  logic [THR_W-1:0] thr_cnt_ff;
  logic cap_clk_en_ff;
  logic mem_clk_en_ff;
  logic [NUM_EV-1:0] irq_trigger_ff;
  logic [NUM_EV-1:0] irq_status_ff;
  logic irq_out_ff;
  irq_if ibus ();

  // True for any address this block answers.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a <= SIG_OFS) || ((a >= FETCH_OFS + ACTIVE_DELTA) && (a <= SIG_OFS + ACTIVE_DELTA));
    mapped = mapped && (a[1:0] == 2'h0);
  endfunction

  // Registers that refuse writes while locked.
  function automatic logic guarded(input logic [ADDR_W-1:0] a);
    guarded = (a == CTRL_OFS) || (a == SIG_OFS);
  endfunction

  // Saturate a requested half width to the split-mode maximum.
  function automatic logic [WIDTH_W-1:0] clamp_w(input logic [WIDTH_W-1:0] w);
    clamp_w = (w > MAX_SPLIT_W) ? MAX_SPLIT_W : w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: read data is sampled in the setup cycle so pready can come from a flop; writes take pwdata in the access cycle.
  assign wr = psel && penable && pwrite && pready_ff;

  always_comb
  begin
    nxt_err = !mapped(paddr);
    nxt_rdata = '0;
    case (paddr)
      LOCK_OFS: nxt_rdata = {{(DATA_W-1){1'b0}}, lock_ff == LOCKED};
      CTRL_OFS: nxt_rdata = ctrl_ff;
      TRIG_OFS: nxt_rdata = {{(DATA_W-3){1'b0}}, pend_sig_ff, pend_otg_ff, pend_src_ff};
      STAT_OFS: nxt_rdata = {{(DATA_W-5){1'b0}}, capture_mode_ff, lock_ff == LOCKED,
                             pend_sig_ff, pend_otg_ff, pend_src_ff};
      IRQ_EN_OFS: nxt_rdata = {{(DATA_W-NUM_EV){1'b0}}, ibus.enable};
      IRQ_ST_OFS: nxt_rdata = {{(DATA_W-NUM_EV){1'b0}}, ibus.status};
      FETCH_OFS: nxt_rdata = sh_fetch;
      EXTERNAL_SOURCE_UNIT_OFS: nxt_rdata = sh_ext;
      MIXER_OFS: nxt_rdata = sh_mix;
      OTG_OFS: nxt_rdata = sh_otg;
      SIG_OFS: nxt_rdata = sh_sig;
      FETCH_OFS + ACTIVE_DELTA: nxt_rdata = fetch_cfg;
      EXTERNAL_SOURCE_UNIT_OFS + ACTIVE_DELTA: nxt_rdata = external_source_unit_cfg;
      MIXER_OFS + ACTIVE_DELTA: nxt_rdata = mixer_cfg;
      OTG_OFS + ACTIVE_DELTA: nxt_rdata = otg_cfg;
      SIG_OFS + ACTIVE_DELTA: nxt_rdata = sig_cfg;
      default: nxt_rdata = '0;
    endcase
  end

  // One wait-free answer: pready rises for the single access cycle after setup.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && nxt_err;
      prdata_ff <= (psel && !penable && !pwrite) ? nxt_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lock: the key flips between locked and unlocked; any other value is ignored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_ff <= LOCKED;
    else if (wr && paddr == LOCK_OFS && pwdata == LOCK_KEY)
    begin
      case (lock_ff)
        LOCKED: lock_ff <= UNLOCKED;
        UNLOCKED: lock_ff <= LOCKED;
        default: lock_ff <= LOCKED;
      endcase
    end
  end

  // Control register, write-protected while locked.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= REG_RESET;
    else if (wr && paddr == CTRL_OFS && !(guarded(paddr) && lock_ff == LOCKED))
      ctrl_ff <= pwdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pending tokens wait for the next frame start; a new trigger beats a release.
  assign src_go = pend_src_ff && frame_start;
  assign otg_own_go = pend_otg_ff && frame_start;
  assign sig_go = pend_sig_ff && frame_start && ctrl_ff[CTL_SIG_OWN];
  assign trig_wr = wr && paddr == TRIG_OFS;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_src_ff <= 1'b0;
      pend_otg_ff <= 1'b0;
      pend_sig_ff <= 1'b0;
    end
    else
    begin
      // One bit arms every fetch and external source together.
      pend_src_ff <= (trig_wr && pwdata[TRG_SRC]) || (pend_src_ff && !frame_start);
      pend_otg_ff <= (trig_wr && pwdata[TRG_OTG]) || (pend_otg_ff && !frame_start);
      pend_sig_ff <= (trig_wr && pwdata[TRG_SIG]) || (pend_sig_ff && !frame_start);
    end
  end

  // Token travel: sources, then mixer inputs, then generator inputs, then downstream.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mix_pri_ff <= 1'b0;
      mix_sec_ff <= 1'b0;
      otg_pri_ff <= 1'b0;
      otg_sec_ff <= 1'b0;
      down_ff <= 1'b0;
    end
    else
    begin
      mix_pri_ff <= src_go;
      mix_sec_ff <= src_go;
      otg_pri_ff <= mix_pri_ff;
      otg_sec_ff <= mix_sec_ff && !ctrl_ff[CTL_MIX_EP];
      // With the generator end points on, only its own start point feeds downstream.
      down_ff <= ctrl_ff[CTL_OTG_EP] ? otg_own_go
               : (otg_pri_ff || otg_sec_ff || otg_own_go);
    end
  end

  assign load_mix = ctrl_ff[CTL_MIX_SEL] ? mix_sec_ff : mix_pri_ff;

  always_comb
  begin
    case (ctrl_ff[CTL_OTG_SEL +: 2])
      OTG_SEL_PRI: load_otg = otg_pri_ff;
      OTG_SEL_SEC: load_otg = otg_sec_ff;
      OTG_SEL_OWN: load_otg = otg_own_go;
      default: load_otg = 1'b0;
    endcase
  end

  // Signature follows downstream tokens or only its own start, never both.
  assign load_sig = ctrl_ff[CTL_SIG_OWN] ? sig_go : down_ff;

  // End point and signature load events.
  always_comb
  begin
    ev = '0;
    ev[EV_MIX_END] = mix_sec_ff && ctrl_ff[CTL_MIX_EP];
    ev[EV_OTG_END] = (otg_pri_ff || otg_sec_ff) && ctrl_ff[CTL_OTG_EP];
    ev[EV_DISP_END] = down_ff;
    ev[EV_SIG_LOAD] = load_sig;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shadowed unit configuration words.
  shadow_reg u_fetch (.pclk(pclk), .presetn(presetn), .wr_en(wr && paddr == FETCH_OFS),
    .wdata(pwdata), .load(src_go), .shadow_q(sh_fetch), .active_q(fetch_cfg));
  shadow_reg u_ext (.pclk(pclk), .presetn(presetn), .wr_en(wr && paddr == EXTERNAL_SOURCE_UNIT_OFS),
    .wdata(pwdata), .load(src_go), .shadow_q(sh_ext), .active_q(external_source_unit_cfg));
  shadow_reg u_mix (.pclk(pclk), .presetn(presetn), .wr_en(wr && paddr == MIXER_OFS),
    .wdata(pwdata), .load(load_mix), .shadow_q(sh_mix), .active_q(mixer_cfg));
  shadow_reg u_otg (.pclk(pclk), .presetn(presetn), .wr_en(wr && paddr == OTG_OFS),
    .wdata(pwdata), .load(load_otg), .shadow_q(sh_otg), .active_q(otg_cfg));
  shadow_reg u_sig (.pclk(pclk), .presetn(presetn),
    .wr_en(wr && paddr == SIG_OFS && !(guarded(paddr) && lock_ff == LOCKED)),
    .wdata(pwdata), .load(load_sig), .shadow_q(sh_sig), .active_q(sig_cfg));

  // Mode, layer enables and width follow their unit loads, so they switch at a frame edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capture_mode_ff <= 1'b0;
      split_ff <= '0;
    end
    else if (load_otg)
    begin
      capture_mode_ff <= sh_otg[OTG_MODE];
      split_ff <= clamp_w(sh_otg[OTG_WIDTH_LO +: WIDTH_W]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_en_ff <= 1'b0;
      cap_en_ff <= 1'b0;
      const_en_ff <= 1'b0;
    end
    else if (load_mix)
    begin
      mem_en_ff <= sh_mix[MIX_MEM_EN];
      cap_en_ff <= sh_mix[MIX_CAP_EN];
      const_en_ff <= sh_mix[MIX_CONST_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Throttle: a free counter gives one enable in every four cycles per stream.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thr_cnt_ff <= '0;
      cap_clk_en_ff <= 1'b1;
      mem_clk_en_ff <= 1'b1;
    end
    else
    begin
      thr_cnt_ff <= thr_cnt_ff + 1'b1;
      cap_clk_en_ff <= !ctrl_ff[CTL_THR_CAP] || (thr_cnt_ff == THR_LAST);
      mem_clk_en_ff <= !ctrl_ff[CTL_THR_MEM] || (thr_cnt_ff == THR_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt bank hookup and registered outputs for the system controller.
  assign ibus.event_hit = ev;
  assign ibus.preset = (wr && paddr == IRQ_SET_OFS) ? pwdata[NUM_EV-1:0] : '0;
  assign ibus.clear = (wr && paddr == IRQ_CLR_OFS) ? pwdata[NUM_EV-1:0] : '0;
  assign ibus.enable_wr = wr && paddr == IRQ_EN_OFS;
  assign ibus.enable_wdata = pwdata[NUM_EV-1:0];

  irq_bank u_irq (.pclk(pclk), .presetn(presetn), .bus(ibus));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_trigger_ff <= '0;
      irq_status_ff <= '0;
      irq_out_ff <= 1'b0;
    end
    else
    begin
      irq_trigger_ff <= ev;
      irq_status_ff <= ibus.status;
      irq_out_ff <= |(ibus.status & ibus.enable);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign capture_mode = capture_mode_ff;
  assign mem_layer_en = mem_en_ff;
  assign cap_layer_en = cap_en_ff;
  assign const_layer_en = const_en_ff;
  assign split_width = split_ff;
  assign cap_clk_en = cap_clk_en_ff;
  assign mem_clk_en = mem_clk_en_ff;
  assign irq_trigger = irq_trigger_ff;
  assign irq_status = irq_status_ff;
  assign irq_out = irq_out_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  release_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mix_pri_ff) |-> $past(frame_start) && $past(pend_src_ff))
    else $error("source token left without a frame start");
  walk_down_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_go && !ctrl_ff[CTL_OTG_EP] |-> ##3 down_ff)
    else $error("token did not reach the display end in three cycles");
  mixer_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    mix_sec_ff && ctrl_ff[CTL_MIX_EP] |=> !otg_sec_ff && ibus.status[EV_MIX_END])
    else $error("mixer end point did not stop the secondary token");
  lock_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == CTRL_OFS && lock_ff == LOCKED |=> ctrl_ff == $past(ctrl_ff))
    else $error("locked control register was written");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_out_ff == $past(|(ibus.status & ibus.enable)))
    else $error("interrupt output does not follow status and enable");
  sig_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[CTL_SIG_OWN] && down_ff && !sig_go |=> !ibus.status[EV_SIG_LOAD]
      || $past(ibus.status[EV_SIG_LOAD]) || $past(ibus.preset[EV_SIG_LOAD]))
    else $error("signature interrupt without a signature load");
  mem_throttle_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[CTL_THR_MEM] && $past(ctrl_ff[CTL_THR_MEM]) && mem_clk_en_ff |=> !mem_clk_en_ff [*3])
    else $error("memory stream throttle ratio wrong");
  split_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    split_ff <= MAX_SPLIT_W)
    else $error("split width above maximum");
endmodule // shadow_cfg_ctrl
`default_nettype wire

// [tb/shadow_cfg_ctrl_tb.sv]
// Self-checking bench for the shadow configuration block over its APB port.
`timescale 1ns/1ps
`default_nettype none
module shadow_cfg_ctrl_tb
  import shadow_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic frame_start = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, rd, fetch_cfg, external_source_unit_cfg, mixer_cfg, otg_cfg, sig_cfg;
  logic pready, pslverr, err, capture_mode, mem_layer_en, cap_layer_en, const_layer_en;
  logic cap_clk_en, mem_clk_en, irq_out;
  logic [WIDTH_W-1:0] split_width;
  logic [NUM_EV-1:0] irq_trigger, irq_status;
  int error_cnt = 0;
  int total_checks = 0;
  logic [DATA_W-1:0] n, m;
  shadow_cfg_ctrl u_shadow_cfg_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_start(frame_start), .fetch_cfg(fetch_cfg),
    .external_source_unit_cfg(external_source_unit_cfg), .mixer_cfg(mixer_cfg), .otg_cfg(otg_cfg), .sig_cfg(sig_cfg),
    .capture_mode(capture_mode), .mem_layer_en(mem_layer_en), .cap_layer_en(cap_layer_en),
    .const_layer_en(const_layer_en), .split_width(split_width), .cap_clk_en(cap_clk_en),
    .mem_clk_en(mem_clk_en), .irq_trigger(irq_trigger), .irq_status(irq_status),
    .irq_out(irq_out));
  // Free-running bus clock, 50 ns period.
  always #25 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers.
  task give_verdict;
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1);
  endtask
  // Writes wait two more edges so delayed status copies have settled.
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask
  task rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
  endtask
  // One frame start pulse, then room for the token to reach the end of the pipeline.
  task frame;
    @(posedge pclk);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // Count the stream clock enables seen over eight edges; unknowns stay visible.
  task thr_count;
    n = '0;
    m = '0;
    repeat (8)
    begin
      @(posedge pclk);
      n += cap_clk_en;
      m += mem_clk_en;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: lock, shadows and tokens, interrupts, throttle and own token.
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(LOCK_OFS, 32'h1);
    wr(CTRL_OFS, 32'h3);
    rdchk(CTRL_OFS, REG_RESET);
    wr(LOCK_OFS, LOCK_KEY);
    rdchk(LOCK_OFS, 32'h0);
    apb(1'b0, 8'hFC, '0);
    chk({31'h0, err}, 32'h1);
    wr(IRQ_CLR_OFS, 32'hF);
    wr(FETCH_OFS, 32'hCAFE0001);
    wr(EXTERNAL_SOURCE_UNIT_OFS, 32'h5A5A0002);
    wr(MIXER_OFS, 32'h5);
    wr(OTG_OFS, 32'h07FF0001);
    rdchk(FETCH_OFS, 32'hCAFE0001);
    rdchk(FETCH_OFS + ACTIVE_DELTA, REG_RESET);
    chk({31'h0, capture_mode}, 32'h0);
    wr(TRIG_OFS, 32'h1);
    rdchk(TRIG_OFS, 32'h1);
    frame;
    chk(fetch_cfg, 32'hCAFE0001);
    chk(external_source_unit_cfg, 32'h5A5A0002);
    chk({29'h0, const_layer_en, cap_layer_en, mem_layer_en}, 32'h5);
    chk({31'h0, capture_mode}, 32'h1);
    chk({21'h0, split_width}, 32'h500);
    chk({31'h0, irq_status[EV_DISP_END]}, 32'h1);
    rdchk(TRIG_OFS, 32'h0);
    // Interrupt bank: enable only the display end event, then preset and clear.
    wr(IRQ_CLR_OFS, 32'hF);
    chk({28'h0, irq_status}, 32'h0);
    wr(IRQ_EN_OFS, 32'h4);
    wr(IRQ_SET_OFS, 32'h2);
    chk({31'h0, irq_out}, 32'h0);
    rdchk(IRQ_ST_OFS, 32'h2);
    wr(IRQ_SET_OFS, 32'h4);
    chk({31'h0, irq_out}, 32'h1);
    chk({28'h0, irq_status}, 32'h6);
    wr(IRQ_CLR_OFS, 32'h4);
    chk({31'h0, irq_out}, 32'h0);
    rdchk(IRQ_ST_OFS, 32'h2);
    // Capture throttle on, generator loads from its own token.
    wr(CTRL_OFS, 32'h41);
    thr_count;
    chk(n, 32'h2);
    chk(m, 32'h8);
    wr(OTG_OFS, 32'h0);
    wr(TRIG_OFS, 32'h2);
    frame;
    chk({31'h0, capture_mode}, 32'h0);
    chk(fetch_cfg, 32'hCAFE0001);
    // End points on, secondary load selects, own signature token, memory throttle.
    wr(CTRL_OFS, 32'hBE);
    thr_count;
    chk(n, 32'h8);
    chk(m, 32'h2);
    wr(IRQ_CLR_OFS, 32'hF);
    wr(MIXER_OFS, 32'h2);
    wr(OTG_OFS, 32'h1);
    wr(SIG_OFS, 32'h1234);
    wr(TRIG_OFS, 32'h1);
    @(posedge pclk);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({28'h0, irq_trigger}, 32'h1);
    @(posedge pclk);
    chk({28'h0, irq_trigger}, 32'h2);
    repeat (4) @(posedge pclk);
    chk({28'h0, irq_status}, 32'h3);
    chk(mixer_cfg, 32'h2);
    chk({29'h0, const_layer_en, cap_layer_en, mem_layer_en}, 32'h2);
    chk(otg_cfg, 32'h0);
    chk(sig_cfg, 32'h0);
    // The generator's own token goes downstream; the signature ignores it in own mode.
    wr(TRIG_OFS, 32'h2);
    frame;
    chk({28'h0, irq_status}, 32'h7);
    chk({31'h0, irq_out}, 32'h1);
    chk(otg_cfg, 32'h0);
    chk(sig_cfg, 32'h0);
    wr(TRIG_OFS, 32'h4);
    frame;
    chk(sig_cfg, 32'h1234);
    chk({28'h0, irq_status}, 32'hF);
    // Relock; writes to the protected control and signature words must be dropped.
    wr(LOCK_OFS, LOCK_KEY);
    wr(CTRL_OFS, 32'h0);
    rdchk(CTRL_OFS, 32'hBE);
    wr(SIG_OFS, 32'h0);
    rdchk(SIG_OFS, 32'h1234);
    give_verdict;
  end
  // Watchdog; the whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    give_verdict;
  end
endmodule // shadow_cfg_ctrl_tb
`default_nettype wire
